// file: dv/twcs_checker.sv
`timescale 1ns/1ps
module twcs_checker #(
  parameter int LOW_CYC  = twcs_pkg::LOW_CYC,
  parameter int HIGH_CYC = twcs_pkg::HIGH_CYC,
  parameter int BUF_CYC  = twcs_pkg::BUF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic [15:0] free_q;
  logic        scl_q;
  logic        sda_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Saturating phase counters; idle bus counts as long free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_q   <= 16'h0000;
      hi_q   <= 16'hffff;
      free_q <= 16'hffff;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      lo_q   <= scl ? 16'h0000 : lo_q + {15'h0000, lo_q != 16'hffff};
      hi_q   <= !scl ? 16'h0000 : hi_q + {15'h0000, hi_q != 16'hffff};
      free_q <= (scl && scl_q && sda && !sda_q) ? 16'h0000
                : free_q + {15'h0000, free_q != 16'hffff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rst_rel;
    $rose(hresetn) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("bus not released after reset");
  // Seen on the wire, so a wrong drive value shows up here
  property p_od;
    (!m_scl_oe || !scl) && (!m_sda_oe || !sda) && (!s_sda_oe || !sda);
  endproperty
  a_od: assert property (p_od)
    else $error("driven line not low");
  property p_low;
    $rose(scl) |-> lo_q >= LOW_CYC;
  endproperty
  a_low: assert property (p_low)
    else $error("clock low phase too short");
  property p_high;
    $fell(scl) |-> hi_q >= HIGH_CYC;
  endproperty
  a_high: assert property (p_high)
    else $error("clock high phase too short");
  property p_stop_su;
    scl && $past(scl) && $rose(sda) |-> hi_q >= HIGH_CYC;
  endproperty
  a_stop_su: assert property (p_stop_su)
    else $error("stop setup too short");
  property p_buf;
    scl && $past(scl) && $fell(sda) |-> free_q >= BUF_CYC;
  endproperty
  a_buf: assert property (p_buf)
    else $error("bus free time too short");
  property p_ack_on;
    $rose(s_sda_oe) |-> !scl && lo_q inside {[16'd1:16'd8]};
  endproperty
  a_ack_on: assert property (p_ack_on)
    else $error("slave pull not early in low phase");
  property p_ack_off;
    $fell(s_sda_oe) |-> !scl && lo_q inside {[16'd1:16'd8]};
  endproperty
  a_ack_off: assert property (p_ack_off)
    else $error("slave release not early in low phase");
  property p_hold;
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_hold: assert property (p_hold)
    else $error("slave data moved while clock high");
  property p_tx_rel;
    s_sda_oe && scl |-> !m_sda_oe;
  endproperty
  a_tx_rel: assert property (p_tx_rel)
    else $error("master holds data in slave slot");
endmodule

// file: dv/two_wire_config_slave_tb.sv
`timescale 1ns/1ps
module two_wire_config_slave_tb;
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic [2:0]   strap;
  logic [7:0]   status_in;
  logic         pd_bit;
  logic         lr_sel;
  logic         ct_sel;
  logic         swr;
  logic [7:0]   cha;
  logic [127:0] reg_map;
  logic [31:0]  seed;
  logic [31:0]  d;
  logic [31:0]  r;
  logic [7:0]   ra;
  logic [7:0]   q;
  logic         nk;
  logic         swr_seen;
  int           fails;
  int           total_checks;

  twcs_if bus_if ();
  // Short phases keep the run small; checker gets the same figures
  twcs_master #(.LOW_CYC(12), .HIGH_CYC(8), .BUF_CYC(8)) twcs_master_inst (
    .hclk(hclk), .hresetn(hresetn), .bus(bus_if), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  twcs_slave twcs_slave_inst (
    .hclk(hclk), .hresetn(hresetn), .bus(bus_if), .addr_strap_high(strap[2]),
    .addr_strap_mid(strap[1]), .addr_strap_low(strap[0]), .status_in(status_in),
    .power_down_bit(pd_bit), .signal_loss_range_sel(lr_sel),
    .channel_tracking_sel(ct_sel), .sw_reset_pulse(swr), .chan_a_control(cha),
    .reg_map(reg_map));
  twcs_checker #(.LOW_CYC(12), .HIGH_CYC(8), .BUF_CYC(8)) twcs_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .m_scl_oe(bus_if.m_scl_oe),
    .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl),
    .sda(bus_if.sda));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [6:0] dev_of(input logic [2:0] s);
    return {4'h5, s[2], ~s[1], ~s[0]};
  endfunction

  task automatic check(input string nm, input logic [127:0] exp, input logic [127:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Entered just after a rising edge; returns at the edge ending the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] ra,
                      input logic [7:0] wd, output logic [7:0] q, output logic nk);
    logic [31:0] v;
    ahb(1'b1, twcs_pkg::HOST_DEV, {25'h0000000, dev}, v);
    ahb(1'b1, twcs_pkg::HOST_REG, {24'h000000, ra}, v);
    ahb(1'b1, twcs_pkg::HOST_WDATA, {24'h000000, wd}, v);
    ahb(1'b1, twcs_pkg::HOST_CMD, {30'h00000000, rd, !rd}, v);
    // Stale done from the last command must clear first
    repeat (2) @(posedge hclk);
    v = 32'h00000000;
    while (v[twcs_pkg::ST_DONE] !== 1'b1) ahb(1'b0, twcs_pkg::HOST_STATUS, 32'h0, v);
    nk = v[twcs_pkg::ST_NACK];
    ahb(1'b0, twcs_pkg::HOST_RDATA, 32'h0, v);
    q = v[7:0];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  always @(posedge hclk) if (swr === 1'b1) swr_seen <= 1'b1;

  initial begin
    repeat (60000) @(posedge hclk);
    fails++;
    complete_run();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    strap = 3'h7;
    status_in = 8'h00;
    seed = 32'h00000061;
    swr_seen = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    check("reset map", 128'h0, reg_map);
    check("reset pins", 128'h0, {pd_bit, lr_sel, ct_sel, swr, cha});
    for (int i = 0; i < 8; i++) begin
      strap <= i[2:0];
      d = rnd();
      ra = 8'h03 + {5'h00, i[2:0]};
      repeat (4) @(posedge hclk);
      xfer(1'b0, dev_of(i[2:0]), ra, d[7:0], q, nk);
      check("hit nack", 128'h0, nk);
      xfer(1'b0, dev_of(i[2:0]) ^ 7'h01, ra, ~d[7:0], q, nk);
      check("miss nack", 128'h1, nk);
      check("map", d[7:0] & ((ra == 8'h06) ? 8'hf7 : 8'hff), reg_map[8*ra +: 8]);
      xfer(1'b1, dev_of(i[2:0]), ra, 8'h00, q, nk);
      check("read back", d[7:0] & ((ra == 8'h06) ? 8'hf7 : 8'hff), q);
    end
    d = rnd();
    xfer(1'b0, 7'h2c, 8'h00, d[7:0] & 8'h7f, q, nk);
    check("general", d[7:0] & 8'h43, reg_map[7:0]);
    check("general pins", {d[6], d[1], d[0]}, {pd_bit, lr_sel, ct_sel});
    xfer(1'b0, 7'h2c, 8'h02, d[15:8], q, nk);
    check("chan a", d[15:8] & 8'hf7, cha);
    xfer(1'b0, 7'h2c, 8'h01, d[23:16], q, nk);
    check("reserved", 128'h0, reg_map[15:8]);
    status_in <= d[31:24];
    xfer(1'b1, 7'h2c, 8'h0e, 8'h00, q, nk);
    check("status", d[31:24], q);
    xfer(1'b0, 7'h2c, 8'h10, 8'h55, q, nk);
    check("range nack", 128'h1, nk);
    ahb(1'b0, twcs_pkg::HOST_REG, 32'h0, r);
    check("host reg", 128'h10, r);
    xfer(1'b0, 7'h2c, 8'h00, 8'h80, q, nk);
    check("soft reset", 128'h0, reg_map);
    check("reset pulse", 128'h1, swr_seen);
    ahb(1'b0, 8'h18, 32'h0, r);
    check("unmapped", 128'h0, r);
    check("hresp", 128'h0, hresp);
    ahb(1'b0, twcs_pkg::HOST_DEV, 32'h0, r);
    check("host dev", 128'h2c, r);
    ahb(1'b0, twcs_pkg::HOST_WDATA, 32'h0, r);
    check("host wdata", 128'h80, r);
    complete_run();
  end
endmodule

// file: verilog/twcs_if.sv
`timescale 1ns/1ps
interface twcs_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface

// file: verilog/twcs_master.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module twcs_master #(
  parameter int LOW_CYC  = twcs_pkg::LOW_CYC,
  parameter int HIGH_CYC = twcs_pkg::HIGH_CYC,
  parameter int BUF_CYC  = twcs_pkg::BUF_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  twcs_if.host             bus,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0000,
    H_START = 4'b0001,
    H_LOW   = 4'b0010,
    H_HIGH  = 4'b0011,
    H_STOP0 = 4'b0100,
    H_STOP1 = 4'b0101,
    H_BUF   = 4'b0110,
    H_RS0   = 4'b0111,
    H_RS1   = 4'b1000
  } twcs_hst_e;

  typedef struct packed {
    twcs_hst_e   st;
    logic [7:0]  tmr;
    logic [3:0]  bitn;
    logic [1:0]  step;
    logic        rd_op;
    logic        rx;
    logic [7:0]  sh;
    logic        scl_oe;
    logic        sda_oe;
    logic        busy;
    logic        nack;
    logic        done;
    logic [7:0]  rdata;
    logic [6:0]  dev;
    logic [7:0]  radr;
    logic [7:0]  wdat;
    logic        ap_wr;
    logic [7:0]  ap_addr;
    logic [31:0] hrdata;
  } twcs_host_s;

  twcs_host_s q;
  twcs_host_s d;
  logic       sda_s;

  if (LOW_CYC < 1 || LOW_CYC > 255 || HIGH_CYC < 1 || HIGH_CYC > 255 ||
      BUF_CYC < 1 || BUF_CYC > 255) begin : g_chk
    $error("twcs_master phase counts must lie in 1..255");
  end

  // Only data is read back; the slave never stretches the clock
  twcs_sync #(.W(1)) u_line (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (bus.sda),
    .q       (sda_s)
  );

  localparam logic [7:0] LOW_LD  = 8'(LOW_CYC - 1);
  localparam logic [7:0] HIGH_LD = 8'(HIGH_CYC - 1);
  localparam logic [7:0] BUF_LD  = 8'(BUF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    // Data bits change only while the clock is held low
    if (q.st == H_LOW) begin
      d.sda_oe = (!q.rx && q.bitn != twcs_pkg::BYTE_BITS) ? !q.sh[7] : 1'b0;
    end else if (q.st == H_STOP0) begin
      d.sda_oe = 1'b1;
    end else if (q.st == H_RS0) begin
      d.sda_oe = 1'b0;
    end

    if (q.st != H_IDLE && q.tmr != 8'h00) begin
      d.tmr = q.tmr - 8'h01;
    end else begin
      case (q.st)
        H_START, H_LOW: begin
          d.st     = (q.st == H_START) ? H_LOW : H_HIGH;
          d.scl_oe = (q.st == H_START);
          d.tmr    = (q.st == H_START) ? LOW_LD : HIGH_LD;
        end
        H_HIGH: begin
          d.st     = H_LOW;
          d.scl_oe = 1'b1;
          d.tmr    = LOW_LD;
          if (q.bitn != twcs_pkg::BYTE_BITS) begin
            d.sh   = {q.sh[6:0], q.rx ? sda_s : 1'b0};
            d.bitn = q.bitn + 4'h1;
          end else begin
            d.bitn = 4'h0;
            if (q.rx) begin
              d.rdata = q.sh;
              d.st    = H_STOP0;
            end else if (sda_s) begin
              d.nack = 1'b1;
              d.st   = H_STOP0;
            end else begin
              d.step = q.step + 2'h1;
              case (q.step)
                2'h0: begin
                  d.sh = q.radr;
                end
                2'h1: begin
                  d.sh = q.rd_op ? {q.dev, twcs_pkg::RW_READ} : q.wdat;
                  d.st = q.rd_op ? H_RS0 : H_LOW;
                end
                default: begin
                  d.rx = q.rd_op;
                  d.st = q.rd_op ? H_LOW : H_STOP0;
                end
              endcase
            end
          end
        end
        H_STOP0, H_RS0: begin
          d.st     = (q.st == H_STOP0) ? H_STOP1 : H_RS1;
          d.scl_oe = 1'b0;
          d.tmr    = HIGH_LD;
        end
        H_STOP1: begin
          d.st     = H_BUF;
          d.sda_oe = 1'b0;
          d.tmr    = BUF_LD;
        end
        H_RS1: begin
          d.st     = H_START;
          d.sda_oe = 1'b1;
          d.tmr    = HIGH_LD;
        end
        H_BUF: begin
          d.st   = H_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
        default: begin
          d.st = H_IDLE;
        end
      endcase
    end

    // AHB-Lite data phase of a write
    if (q.ap_wr) begin
      case (q.ap_addr)
        twcs_pkg::HOST_CMD: begin
          if (!q.busy && (hwdata[twcs_pkg::CMD_WRITE] || hwdata[twcs_pkg::CMD_READ])) begin
            d.st     = H_START;
            d.sda_oe = 1'b1;
            d.tmr    = HIGH_LD;
            d.busy   = 1'b1;
            d.done   = 1'b0;
            d.nack   = 1'b0;
            d.rd_op  = hwdata[twcs_pkg::CMD_READ];
            d.rx     = 1'b0;
            d.step   = 2'h0;
            d.bitn   = 4'h0;
            d.sh     = {q.dev, twcs_pkg::RW_WRITE};
          end
        end
        twcs_pkg::HOST_DEV:   d.dev  = hwdata[6:0];
        twcs_pkg::HOST_REG:   d.radr = hwdata[7:0];
        twcs_pkg::HOST_WDATA: d.wdat = hwdata[7:0];
        default: ;
      endcase
    end

    // Address phase: latch write target, prepare read data
    d.ap_wr = hsel && htrans[1] && hready && hwrite;
    d.ap_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        twcs_pkg::HOST_DEV:    d.hrdata = {25'h0, q.dev};
        twcs_pkg::HOST_REG:    d.hrdata = {24'h0, q.radr};
        twcs_pkg::HOST_WDATA:  d.hrdata = {24'h0, q.wdat};
        twcs_pkg::HOST_STATUS: d.hrdata = {29'h0, q.done, q.nack, q.busy};
        twcs_pkg::HOST_RDATA:  d.hrdata = {24'h0, q.rdata};
        default:               d.hrdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q    <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = q.sda_oe;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = q.hrdata;
endmodule

// file: verilog/twcs_pkg.sv
package twcs_pkg;
  // Core clock and two-wire timing
  localparam int CLK_NS    = 20;
  localparam int T_LOW_NS  = 1300;
  localparam int T_HIGH_NS = 600;
  localparam int T_BUF_NS  = 1300;
  localparam int LOW_CYC   = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC  = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUF_CYC   = (T_BUF_NS + CLK_NS - 1) / CLK_NS;

  // Framing
  localparam logic [3:0] DEV_ADDR_HI = 4'h5;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic       RW_WRITE    = 1'b0;
  localparam logic       RW_READ     = 1'b1;

  // Device register map
  localparam logic [7:0] REG_LAST     = 8'h0f;
  localparam logic [3:0] REG_GENERAL  = 4'h0;
  localparam logic [3:0] REG_RSVD_ONE = 4'h1;
  localparam logic [3:0] REG_CHA_CTRL = 4'h2;
  localparam logic [3:0] REG_CHB_CTRL = 4'h6;
  localparam logic [3:0] REG_STATUS   = 4'he;
  localparam logic [7:0] MASK_GENERAL = 8'hc3;
  localparam logic [7:0] MASK_CTRL    = 8'hf7;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam int GEN_SW_RESET = 7;
  localparam int GEN_PWRDN    = 6;
  localparam int GEN_SIGNAL_LOSS_RANGE_SEL   = 1;
  localparam int GEN_TRACK    = 0;

  // Controller registers on AHB-Lite
  localparam logic [7:0] HOST_CMD    = 8'h00;
  localparam logic [7:0] HOST_DEV    = 8'h04;
  localparam logic [7:0] HOST_REG    = 8'h08;
  localparam logic [7:0] HOST_WDATA  = 8'h0c;
  localparam logic [7:0] HOST_STATUS = 8'h10;
  localparam logic [7:0] HOST_RDATA  = 8'h14;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ  = 1;
  localparam int ST_BUSY   = 0;
  localparam int ST_NACK   = 1;
  localparam int ST_DONE   = 2;
endpackage

// file: verilog/twcs_slave.sv
`timescale 1ns/1ps
// Summary of operation
// - Direction bit zero writes, one reads
// - Open straps give address 0101100
// - Straps low give address 0101011
// - Address is 0101, strap high, inverted others
// - Write: address, register address, data, stop
// - Slave only, never drives clock
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Repeated start decodes a new address
// - Unlimited bytes, each acknowledged by receiver
// - Receiver pulls data low in ack slot
// - Address mismatch leaves data released
// - Refused byte gets not-acknowledge, master stops
// - Master clock at most 400 kHz; default phases give a 95 hclk cycle (1900 ns) period, about 526 kHz
// - Master keeps bus free and start holds
// - Registers 0x00 to 0x0F read and write; writes to 0x01 and 0x0E are dropped
// - General settings bit layout
// - Channel A control bit layout
// - Reads return register contents
module twcs_slave (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  twcs_if.dev               bus,
  input  wire logic         addr_strap_high,
  input  wire logic         addr_strap_mid,
  input  wire logic         addr_strap_low,
  input  wire logic [7:0]   status_in,
  output logic              power_down_bit,
  output logic              signal_loss_range_sel,
  output logic              channel_tracking_sel,
  output logic              sw_reset_pulse,
  output logic [7:0]        chan_a_control,
  output logic [127:0]      reg_map
);

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DEV  = 3'b001,
    S_REG  = 3'b010,
    S_WR   = 3'b011,
    S_TX   = 3'b100
  } twcs_dst_e;

  typedef struct packed {
    twcs_dst_e        st;
    logic             scl_p;
    logic             sda_p;
    logic [3:0]       cnt;
    logic             in_ack;
    logic             ack;
    logic [7:0]       sh;
    logic [7:0]       ptr;
    logic             sda_oe;
    logic             rst_p;
    logic [15:0][7:0] regs;
  } twcs_dev_s;

  twcs_dev_s  q;
  twcs_dev_s  d;
  logic [1:0] line_s;
  logic [2:0] strap_s;
  logic       scl_s;
  logic       sda_s;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [6:0] own_addr;

  ////////////////////////////////////////////////////////////////////////
  // Bus lines and straps are asynchronous pins
  twcs_sync #(.W(2)) u_line (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({bus.scl, bus.sda}),
    .q       (line_s)
  );

  twcs_sync #(.W(3)) u_strap (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({addr_strap_high, addr_strap_mid, addr_strap_low}),
    .q       (strap_s)
  );

  assign scl_s    = line_s[1];
  assign sda_s    = line_s[0];
  assign own_addr = {twcs_pkg::DEV_ADDR_HI, strap_s[2], ~strap_s[1], ~strap_s[0]};

  ////////////////////////////////////////////////////////////////////////
  // Writable bits per register; reserved bits stay zero
  function automatic logic [7:0] wr_mask(input logic [3:0] a);
    case (a)
      twcs_pkg::REG_GENERAL:  wr_mask = twcs_pkg::MASK_GENERAL;
      twcs_pkg::REG_RSVD_ONE: wr_mask = 8'h00;
      twcs_pkg::REG_CHA_CTRL: wr_mask = twcs_pkg::MASK_CTRL;
      twcs_pkg::REG_CHB_CTRL: wr_mask = twcs_pkg::MASK_CTRL;
      twcs_pkg::REG_STATUS:   wr_mask = 8'h00;
      default:                wr_mask = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input twcs_dev_s s, input logic [7:0] a,
                                         input logic [7:0] stat);
    if (a > twcs_pkg::REG_LAST) begin
      rd_byte = 8'h00;
    end else if (a[3:0] == twcs_pkg::REG_STATUS) begin
      rd_byte = stat;
    end else begin
      rd_byte = s.regs[a[3:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d       = q;
    d.rst_p = 1'b0;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    rise    = scl_s && !q.scl_p;
    fall    = !scl_s && q.scl_p;
    start   = scl_s && q.scl_p && q.sda_p && !sda_s;
    stop    = scl_s && q.scl_p && !q.sda_p && sda_s;

    if (start) begin
      // Repeated start restarts address decode from any state
      d.st     = S_DEV;
      d.cnt    = 4'h0;
      d.in_ack = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st     = S_IDLE;
      d.in_ack = 1'b0;
      d.sda_oe = 1'b0;
    end else if (q.st != S_IDLE && rise) begin
      if (q.cnt != twcs_pkg::BYTE_BITS) begin
        d.sh  = (q.st == S_TX) ? {q.sh[6:0], 1'b0} : {q.sh[6:0], sda_s};
        d.cnt = q.cnt + 4'h1;
      end else if (q.st == S_TX) begin
        d.ack = !sda_s;
      end
    end else if (q.st != S_IDLE && fall) begin
      if (q.cnt == twcs_pkg::BYTE_BITS && !q.in_ack) begin
        // Byte complete: decide the answer for the ack slot
        d.in_ack = 1'b1;
        case (q.st)
          S_DEV: begin
            d.ack = (q.sh[7:1] == own_addr);
          end
          S_REG: begin
            d.ack = (q.sh <= twcs_pkg::REG_LAST);
            d.ptr = q.sh;
          end
          S_WR: begin
            d.ack = (q.ptr <= twcs_pkg::REG_LAST);
            if (q.ptr <= twcs_pkg::REG_LAST) begin
              d.regs[q.ptr[3:0]] = q.sh & wr_mask(q.ptr[3:0]);
              d.ptr              = q.ptr + 8'h01;
              if (q.ptr[3:0] == twcs_pkg::REG_GENERAL && q.sh[twcs_pkg::GEN_SW_RESET]) begin
                d.regs  = '0;
                d.rst_p = 1'b1;
              end
            end
          end
          default: begin
            d.ack = 1'b0;
          end
        endcase
        // Only a receiving slave pulls the line; transmitter releases
        d.sda_oe = (q.st != S_TX) && d.ack;
      end else if (q.in_ack) begin
        d.in_ack = 1'b0;
        d.cnt    = 4'h0;
        d.sda_oe = 1'b0;
        case (q.st)
          S_DEV: begin
            if (!q.ack) begin
              d.st = S_IDLE;
            end else if (q.sh[0] == twcs_pkg::RW_READ) begin
              d.st     = S_TX;
              d.sh     = rd_byte(q, q.ptr, status_in);
              d.sda_oe = !d.sh[7];
            end else begin
              d.st = S_REG;
            end
          end
          S_REG: begin
            d.st = q.ack ? S_WR : S_IDLE;
          end
          S_WR: begin
            d.st = q.ack ? S_WR : S_IDLE;
          end
          S_TX: begin
            // Master ack asks for the next byte, nack ends the read
            if (q.ack) begin
              d.ptr    = q.ptr + 8'h01;
              d.sh     = rd_byte(q, d.ptr, status_in);
              d.sda_oe = !d.sh[7];
            end else begin
              d.st = S_IDLE;
            end
          end
          default: begin
            d.st = S_IDLE;
          end
        endcase
      end else if (q.st == S_TX) begin
        d.sda_oe = !q.sh[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q        <= '0;
      q.st     <= S_IDLE;
      q.scl_p  <= 1'b1;
      q.sda_p  <= 1'b1;
      q.regs   <= {16{twcs_pkg::REG_RESET}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain data only; clock is never driven
  assign bus.s_sda_o            = 1'b0;
  assign bus.s_sda_oe           = q.sda_oe;
  assign power_down_bit         = q.regs[twcs_pkg::REG_GENERAL][twcs_pkg::GEN_PWRDN];
  assign signal_loss_range_sel  = q.regs[twcs_pkg::REG_GENERAL][twcs_pkg::GEN_SIGNAL_LOSS_RANGE_SEL];
  assign channel_tracking_sel   = q.regs[twcs_pkg::REG_GENERAL][twcs_pkg::GEN_TRACK];
  assign sw_reset_pulse         = q.rst_p;
  assign chan_a_control         = q.regs[twcs_pkg::REG_CHA_CTRL];
  assign reg_map                = q.regs;
endmodule

// file: verilog/twcs_sync.sv
`timescale 1ns/1ps
module twcs_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("twcs_sync needs W >= 1");
  end

  // Resets high: idle bus level and pulled-up straps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
